// file: pkg/ira_bus_if.sv
`timescale 1ns/100ps
interface ira_bus_if;
  import ira_pkg::*;

  // ------------------------------------------------------------
  // instruction bus
  // ------------------------------------------------------------
  logic instrReq;
  logic instrBurst;
  logic instrWe;
  logic [ADDR_W-1:0] instrAddr;
  logic [DATA_W-1:0] instrWdata;
  logic [DATA_W-1:0] instrRdata;
  logic instr_ready_in;
  logic instr_fault_in;

  // ------------------------------------------------------------
  // data bus
  // ------------------------------------------------------------
  logic dataReq;
  logic dataBurst;
  logic dataWe;
  logic [ADDR_W-1:0] dataAddr;
  logic [DATA_W-1:0] dataWdata;
  logic [OPT_W-1:0] access_option_code;
  logic [DATA_W-1:0] dataRdata;
  logic data_ready_in;
  logic data_fault_in;

  // ------------------------------------------------------------
  // channel control and late fault signalling
  // ------------------------------------------------------------
  logic bus_invalid;
  logic trap_req_0;
  logic trap_req_1;

  modport cpu (
    output instrReq, instrBurst, instrWe, instrAddr, instrWdata,
    output dataReq, dataBurst, dataWe, dataAddr, dataWdata, access_option_code,
    output bus_invalid,
    input instrRdata, instr_ready_in, instr_fault_in,
    input dataRdata, data_ready_in, data_fault_in, trap_req_0, trap_req_1
  );

  modport mem (
    input instrReq, instrBurst, instrWe, instrAddr, instrWdata,
    input dataReq, dataBurst, dataWe, dataAddr, dataWdata, access_option_code,
    input bus_invalid,
    output instrRdata, instr_ready_in, instr_fault_in,
    output dataRdata, data_ready_in, data_fault_in, trap_req_0, trap_req_1
  );

endinterface : ira_bus_if

// file: pkg/ira_pkg.sv
package ira_pkg;

  // ------------------------------------------------------------
  // widths and memory map
  // ------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int OPT_W = 3;
  localparam int IRAM_DEPTH = 1024;
  localparam logic [ADDR_W-1:0] IRAM_BASE = 16'h0000;
  localparam logic [ADDR_W-1:0] IRAM_END = IRAM_BASE + ADDR_W'(IRAM_DEPTH);

  // ------------------------------------------------------------
  // option code for a data-bus read of instruction memory
  // ------------------------------------------------------------
  localparam logic [OPT_W-1:0] OPT_IROM_READ = 3'h4;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TIMEOUT_NS = 10240;
  localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int TMO_W = 16;
  localparam int EDC_EXTRA = 1;
  localparam int PRIME_W = 2;

  // ------------------------------------------------------------
  // arbiter states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ARB_IDLE = 3'h0,
    ARB_IPRIME = 3'h1,
    ARB_IFETCH = 3'h3,
    ARB_DPRIME = 3'h4,
    ARB_DSERVE = 3'h6
  } ira_arb_type;

endpackage : ira_pkg

// file: rtl/ira_bus_timeout.sv
`timescale 1ns/100ps
module ira_bus_timeout
#(
  parameter int LIMIT = ira_pkg::TIMEOUT_CYC,
  parameter int CW = ira_pkg::TMO_W
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pending,
  input wire logic restart,
  output logic expired
);
  import ira_pkg::*;

  logic [CW-1:0] cntQ;
  wire atLimit = (cntQ == CW'(LIMIT - 1));

  // restarts on each new request or ready, pulses at the limit and again every LIMIT cycles while still pending
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cntQ <= '0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= pending && !restart && atLimit;
      if (restart || !pending || atLimit)
        cntQ <= '0;
      else
        cntQ <= cntQ + CW'(1);
    end
  end

endmodule : ira_bus_timeout

// file: rtl/ira_cpu_end.sv
`timescale 1ns/100ps
module ira_cpu_end
(
  input wire logic core_clk,
  input wire logic rst_n,
  ira_bus_if.cpu bus,
  input wire logic fetchReq,
  input wire logic fetchBurst,
  input wire logic [ira_pkg::ADDR_W-1:0] fetchAddr,
  output logic [ira_pkg::DATA_W-1:0] fetchData,
  output logic fetchDone,
  output logic fetchErr,
  input wire logic loadReq,
  input wire logic loadBurst,
  input wire logic loadWe,
  input wire logic [ira_pkg::ADDR_W-1:0] loadAddr,
  input wire logic [ira_pkg::DATA_W-1:0] loadWdata,
  input wire logic [ira_pkg::OPT_W-1:0] loadOpt,
  output logic [ira_pkg::DATA_W-1:0] loadData,
  output logic loadDone,
  output logic loadErr,
  input wire logic dmaReq,
  output logic dmaGrant,
  input wire logic dmaInstrWe,
  input wire logic [ira_pkg::DATA_W-1:0] dmaInstrWdata,
  output logic trapSeen
);
  import ira_pkg::*;

  logic grantQ;
  logic invQ;
  logic trapQ;

  // ------------------------------------------------------------
  // channel hand-over
  // ------------------------------------------------------------
  // grant taken only while no fetch is being requested, then kept as long as dmaReq stays high
  wire grantD = grantQ ? dmaReq : (dmaReq && !fetchReq);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      grantQ <= 1'b0;
      invQ <= 1'b0;
      trapQ <= 1'b0;
    end
    else
    begin
      grantQ <= grantD;
      invQ <= grantD != grantQ;
      trapQ <= bus.trap_req_0 || bus.trap_req_1;
    end
  end

  // ------------------------------------------------------------
  // instruction bus: fetch only, writes belong to a DMA owner
  // ------------------------------------------------------------
  assign bus.instrReq = grantQ ? dmaInstrWe : fetchReq;
  assign bus.instrBurst = !grantQ && fetchBurst;
  assign bus.instrWe = grantQ && dmaInstrWe;
  assign bus.instrAddr = fetchAddr;
  assign bus.instrWdata = dmaInstrWdata;

  // ------------------------------------------------------------
  // data bus
  // ------------------------------------------------------------
  assign bus.dataReq = loadReq;
  assign bus.dataBurst = loadBurst;
  assign bus.dataWe = loadWe;
  assign bus.dataAddr = loadAddr;
  assign bus.dataWdata = loadWdata;
  assign bus.access_option_code = loadOpt;
  assign bus.bus_invalid = invQ;

  // ------------------------------------------------------------
  // answers, faults heeded only while an access is pending
  // ------------------------------------------------------------
  assign fetchData = bus.instrRdata;
  assign fetchDone = bus.instr_ready_in && bus.instrReq;
  assign fetchErr = bus.instr_fault_in && bus.instrReq;
  assign loadData = bus.dataRdata;
  assign loadDone = bus.data_ready_in && bus.dataReq;
  assign loadErr = bus.data_fault_in && bus.dataReq;
  assign dmaGrant = grantQ;
  assign trapSeen = trapQ;

endmodule : ira_cpu_end

// file: rtl/ira_mem_end.sv
`timescale 1ns/100ps
// Overview of operation
// - processor samples faults only while access pending
// - fault asserted no later than ready
// - late faults may signal through trap lines
// - error pipeline adds one cycle to first access
// - unmapped address never gets ready
// - bus time-out ends unanswered access with error
// - processor never writes over instruction bus
// - option code 100 reads instruction memory
// - instruction memory read/write over data bus
// - data access waits for fetch done or stall
// - fetch held off during data burst
// - no fetches while DMA owns channel
// - DMA data preempts suspended instruction burst
// - DMA requests channel before instruction memory access
// - without data port DMA is sole writer
// - no arbiter or memory change while bus invalid
module ira_mem_end
#(
  parameter int DEPTH = ira_pkg::IRAM_DEPTH,
  parameter int PIPE_EXTRA = ira_pkg::EDC_EXTRA,
  parameter bit DATA_PORT_EN = 1'b1,
  parameter int TMO_LIMIT = ira_pkg::TIMEOUT_CYC
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  ira_bus_if.mem bus,
  input wire logic injectParityErr,
  output ira_pkg::ira_arb_type arbState,
  output logic [ira_pkg::ADDR_W-1:0] faultAddr,
  output logic [ira_pkg::TMO_W-1:0] faultCount
);
  import ira_pkg::*;

  localparam int IDX_W = $clog2(DEPTH);

  // ------------------------------------------------------------
  // storage: data word plus even parity bit
  // ------------------------------------------------------------
  logic [DATA_W:0] ram [DEPTH];

  ira_arb_type stateQ;
  ira_arb_type stateD;
  logic [IDX_W-1:0] ptrQ;
  logic [PRIME_W-1:0] primeQ;
  logic iRdyQ;
  logic dRdyQ;
  logic faultQ;
  logic [DATA_W-1:0] rdataQ;
  logic iReqPrevQ;
  logic dReqPrevQ;
  logic trap0Q;
  logic trap1Q;
  logic [ADDR_W-1:0] faultAddrQ;
  logic [TMO_W-1:0] faultCntQ;
  logic iTmo;
  logic dTmo;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire live = !bus.bus_invalid;
  wire iHit = (bus.instrAddr >= IRAM_BASE) && (bus.instrAddr < IRAM_END);
  wire dRange = (bus.dataAddr >= IRAM_BASE) && (bus.dataAddr < IRAM_END);
  wire dOptOk = bus.dataWe || (bus.access_option_code == OPT_IROM_READ);
  wire dHit = DATA_PORT_EN && dRange && dOptOk;
  wire iWant = bus.instrReq && iHit;
  wire dWant = bus.dataReq && dHit;
  wire [IDX_W-1:0] iIdx = IDX_W'(bus.instrAddr - IRAM_BASE);
  wire [IDX_W-1:0] dIdx = IDX_W'(bus.dataAddr - IRAM_BASE);

  // ------------------------------------------------------------
  // ownership
  // ------------------------------------------------------------
  wire iOwn = (stateQ == ARB_IPRIME) || (stateQ == ARB_IFETCH);
  wire dOwn = (stateQ == ARB_DPRIME) || (stateQ == ARB_DSERVE);
  wire iMore = bus.instrReq && bus.instrBurst && !bus.instrWe;
  wire dMore = bus.dataReq && bus.dataBurst && !bus.dataWe;
  wire primed = (primeQ == '0);

  always_comb
  begin
    stateD = stateQ;
    case (stateQ)
      ARB_IDLE:
        // data first: a stalled fetch is preempted, a running one finished first
        if (dWant)
          stateD = ARB_DPRIME;
        else if (iWant)
          stateD = ARB_IPRIME;
      ARB_IPRIME:
        if (!bus.instrReq)
          stateD = ARB_IDLE;
        else if (primed)
          stateD = ARB_IFETCH;
      ARB_IFETCH:
        if (!iMore)
          stateD = ARB_IDLE;
      ARB_DPRIME:
        if (!bus.dataReq)
          stateD = ARB_IDLE;
        else if (primed)
          stateD = ARB_DSERVE;
      ARB_DSERVE:
        if (!dMore)
          stateD = ARB_IDLE;
      default:
        stateD = ARB_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // word transfer
  // ------------------------------------------------------------
  wire serve = (stateQ != ARB_IDLE) && primed && (stateD != ARB_IDLE);
  wire wr = serve && (iOwn ? bus.instrWe : bus.dataWe);
  wire [DATA_W-1:0] wdata = iOwn ? bus.instrWdata : bus.dataWdata;
  wire wpar = (^wdata) ^ injectParityErr;
  wire [DATA_W:0] word = ram[ptrQ];
  wire wordBad = ^word;

  always_ff @(posedge core_clk)
  begin
    if (live && wr)
      ram[ptrQ] <= {wpar, wdata};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stateQ <= ARB_IDLE;
      ptrQ <= '0;
      primeQ <= '0;
      iRdyQ <= 1'b0;
      dRdyQ <= 1'b0;
      faultQ <= 1'b0;
      rdataQ <= '0;
    end
    else if (live)
    begin
      stateQ <= stateD;
      iRdyQ <= serve && iOwn;
      dRdyQ <= serve && dOwn;
      if (stateQ == ARB_IDLE)
      begin
        ptrQ <= dWant ? dIdx : iIdx;
        primeQ <= PRIME_W'(PIPE_EXTRA);
      end
      else if (!primed)
        primeQ <= primeQ - PRIME_W'(1);
      else if (serve)
      begin
        ptrQ <= ptrQ + IDX_W'(1);
        rdataQ <= word[DATA_W-1:0];
        faultQ <= !wr && wordBad;
      end
    end
    else
    begin
      iRdyQ <= 1'b0;
      dRdyQ <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // time-outs for accesses that nobody answers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      iReqPrevQ <= 1'b0;
      dReqPrevQ <= 1'b0;
    end
    else
    begin
      iReqPrevQ <= bus.instrReq;
      dReqPrevQ <= bus.dataReq;
    end
  end

  // a request held off by the other owner is not counted
  wire iPend = bus.instrReq && live && !dOwn;
  wire dPend = bus.dataReq && live && !iOwn;
  wire iRestart = iRdyQ || (bus.instrReq && !iReqPrevQ);
  wire dRestart = dRdyQ || (bus.dataReq && !dReqPrevQ);

  ira_bus_timeout #(
    .LIMIT(TMO_LIMIT),
    .CW(TMO_W)
  ) instrTimeout (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pending(iPend),
    .restart(iRestart),
    .expired(iTmo)
  );

  ira_bus_timeout #(
    .LIMIT(TMO_LIMIT),
    .CW(TMO_W)
  ) dataTimeout (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pending(dPend),
    .restart(dRestart),
    .expired(dTmo)
  );

  // ------------------------------------------------------------
  // late fault report and fault log
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      trap0Q <= 1'b0;
      trap1Q <= 1'b0;
      faultAddrQ <= '0;
      faultCntQ <= '0;
    end
    else
    begin
      trap0Q <= dTmo;
      trap1Q <= iTmo;
      if (iTmo || dTmo || ((iRdyQ || dRdyQ) && faultQ))
      begin
        faultAddrQ <= iTmo ? bus.instrAddr : bus.dataAddr;
        faultCntQ <= faultCntQ + TMO_W'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // responses
  // ------------------------------------------------------------
  assign bus.instr_ready_in = iRdyQ;
  assign bus.data_ready_in = dRdyQ;
  assign bus.instr_fault_in = (iRdyQ && faultQ) || iTmo;
  assign bus.data_fault_in = (dRdyQ && faultQ) || dTmo;
  assign bus.instrRdata = rdataQ;
  assign bus.dataRdata = rdataQ;
  assign bus.trap_req_0 = trap0Q;
  assign bus.trap_req_1 = trap1Q;
  assign arbState = stateQ;
  assign faultAddr = faultAddrQ;
  assign faultCount = faultCntQ;

endmodule : ira_mem_end

// file: verification/ira_bus_monitor.sv
`timescale 1ns/100ps
module ira_bus_monitor
  import ira_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic instrReq,
  input wire logic instrBurst,
  input wire logic instrWe,
  input wire logic [ira_pkg::ADDR_W-1:0] instrAddr,
  input wire logic instr_ready_in,
  input wire logic dataReq,
  input wire logic dataWe,
  input wire logic [ira_pkg::ADDR_W-1:0] dataAddr,
  input wire logic [ira_pkg::OPT_W-1:0] access_option_code,
  input wire logic data_ready_in,
  input wire logic data_fault_in,
  input wire logic bus_invalid,
  input wire logic trap_req_0
);
  default clocking mcb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // access timing and ownership
  // ----------------------------------------
  AST_INSTR_LATENCY:
    assert property ($rose(instrReq) && !dataReq && !bus_invalid && instrAddr < IRAM_END
      |=> !instr_ready_in [*2] ##1 instr_ready_in)
    else $error("instruction ready not three cycles after request");
  AST_DATA_LATENCY:
    assert property ($rose(dataReq) && !instrReq && !bus_invalid && dataAddr < IRAM_END
      && (dataWe || access_option_code == OPT_IROM_READ)
      |=> !data_ready_in [*2] ##1 data_ready_in)
    else $error("data ready not three cycles after request");
  AST_ONE_OWNER:
    assert property (!(instr_ready_in && data_ready_in))
    else $error("both buses answered in one cycle");
  AST_SWITCH_GAP:
    assert property (instr_ready_in |=> !data_ready_in [*2])
    else $error("data served right behind a fetch word");
  AST_INVALID_IDLE:
    assert property (bus_invalid |-> !instr_ready_in && !data_ready_in)
    else $error("ready during invalid channel cycle");
  AST_DMA_NO_BURST:
    assert property (instrWe |-> !instrBurst)
    else $error("burst on instruction bus write");

  // ----------------------------------------
  // unanswered accesses
  // ----------------------------------------
  AST_DATA_TIMEOUT:
    assert property ($rose(dataReq) && !instrReq && dataAddr >= IRAM_END
      |-> (!data_ready_in) throughout (##[1:12] data_fault_in))
    else $error("unmapped access not ended by fault");
  AST_TMO_PULSE:
    assert property (data_fault_in && !data_ready_in |=> !data_fault_in)
    else $error("time-out fault longer than one cycle");
  AST_TRAP_DATA:
    assert property (data_fault_in && !data_ready_in |=> trap_req_0)
    else $error("no trap after data time-out");

  CV_BURST: cover property (instrReq && instrBurst && instr_ready_in);
  CV_TMO: cover property (data_fault_in && !data_ready_in);
  CV_DMA_WR: cover property (instrWe && instr_ready_in);
endmodule : ira_bus_monitor

// file: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import ira_pkg::*;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH %0t %h %h", $time, (a), (b)); end end
  logic core_clk, rst_n, injectParityErr, fetchReq, fetchBurst, fetchDone, fetchErr;
  logic loadReq, loadBurst, loadWe, loadDone, loadErr, dmaReq, dmaGrant, dmaInstrWe;
  logic trapSeen, trapHit;
  logic [ADDR_W-1:0] fetchAddr, loadAddr, faultAddr;
  logic [DATA_W-1:0] fetchData, loadData, loadWdata, dmaInstrWdata, q;
  logic [OPT_W-1:0] loadOpt;
  logic [TMO_W-1:0] faultCount;
  logic [DATA_W-1:0] w[4];
  logic e;
  ira_arb_type arbState;
  int failures, compares, cyc;

  ira_bus_if ira_bus_if_inst();
  ira_mem_end #(.TMO_LIMIT(8)) ira_mem_end_inst(.core_clk(core_clk), .rst_n(rst_n),
    .bus(ira_bus_if_inst.mem), .injectParityErr(injectParityErr), .arbState(arbState),
    .faultAddr(faultAddr), .faultCount(faultCount));
  ira_cpu_end ira_cpu_end_inst(.core_clk(core_clk), .rst_n(rst_n), .bus(ira_bus_if_inst.cpu),
    .fetchReq(fetchReq), .fetchBurst(fetchBurst), .fetchAddr(fetchAddr),
    .fetchData(fetchData), .fetchDone(fetchDone), .fetchErr(fetchErr), .loadReq(loadReq),
    .loadBurst(loadBurst), .loadWe(loadWe), .loadAddr(loadAddr), .loadWdata(loadWdata),
    .loadOpt(loadOpt), .loadData(loadData), .loadDone(loadDone), .loadErr(loadErr),
    .dmaReq(dmaReq), .dmaGrant(dmaGrant), .dmaInstrWe(dmaInstrWe),
    .dmaInstrWdata(dmaInstrWdata), .trapSeen(trapSeen));
  ira_bus_monitor ira_bus_monitor_inst(.core_clk(core_clk), .rst_n(rst_n),
    .instrReq(ira_bus_if_inst.instrReq), .instrBurst(ira_bus_if_inst.instrBurst),
    .instrWe(ira_bus_if_inst.instrWe), .instrAddr(ira_bus_if_inst.instrAddr),
    .instr_ready_in(ira_bus_if_inst.instr_ready_in), .dataReq(ira_bus_if_inst.dataReq),
    .dataWe(ira_bus_if_inst.dataWe), .dataAddr(ira_bus_if_inst.dataAddr),
    .access_option_code(ira_bus_if_inst.access_option_code),
    .data_ready_in(ira_bus_if_inst.data_ready_in), .data_fault_in(ira_bus_if_inst.data_fault_in),
    .bus_invalid(ira_bus_if_inst.bus_invalid), .trap_req_0(ira_bus_if_inst.trap_req_0));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (trapSeen === 1'b1)
      trapHit <= 1'b1;
    if (cyc > 2000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task tally_and_finish;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // one data-bus access, waits for done or fault
  // ----------------------------------------
  task ld(input logic we, input logic [2:0] opt, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    loadReq <= 1'b1;
    loadWe <= we;
    loadOpt <= opt;
    loadAddr <= a;
    loadWdata <= d;
    n = 0;
    while (loadDone !== 1'b1 && loadErr !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    q = loadData;
    e = loadErr;
    @(posedge core_clk);
    loadReq <= 1'b0;
  endtask : ld

  // ----------------------------------------
  // fetch of k words, burst dropped with the last
  // ----------------------------------------
  task fe(input logic [15:0] a, input int k);
    int n, got;
    @(posedge core_clk);
    fetchReq <= 1'b1;
    fetchBurst <= (k > 1);
    fetchAddr <= a;
    n = 0;
    got = 0;
    e = 1'b0;
    w = '{default: 'x};
    while (got < k && e !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
      if (fetchErr === 1'b1)
        e = 1'b1;
      if (fetchDone === 1'b1)
      begin
        w[got] = fetchData;
        got++;
      end
      @(posedge core_clk);
      if (got >= k - 1)
        fetchBurst <= 1'b0;
    end
    fetchReq <= 1'b0;
  endtask : fe

  task t_rw;
    ld(1'b1, 3'h0, 16'h0010, 32'hA5A5_0001);
    `CHK(e, 1'b0)
    ld(1'b0, OPT_IROM_READ, 16'h0010, 32'h0);
    `CHK(q, 32'hA5A5_0001)
    fe(16'h0010, 1);
    `CHK(w[0], 32'hA5A5_0001)
    $display("rw done");
  endtask : t_rw

  task t_burst;
    for (int i = 0; i < 4; i++)
      ld(1'b1, 3'h0, 16'h0020 + 16'(i), 32'h1000_0000 + 32'(i));
    fe(16'h0020, 4);
    for (int i = 0; i < 4; i++)
      `CHK(w[i], 32'h1000_0000 + 32'(i))
    $display("burst done");
  endtask : t_burst

  task t_fault;
    injectParityErr <= 1'b1;
    ld(1'b1, 3'h0, 16'h0030, 32'h0000_0030);
    injectParityErr <= 1'b0;
    ld(1'b0, OPT_IROM_READ, 16'h0030, 32'h0);
    `CHK(e, 1'b1)
    fe(16'h0030, 1);
    `CHK(e, 1'b1)
    `CHK(w[0], 32'h0000_0030)
    trapHit <= 1'b0;
    ld(1'b0, OPT_IROM_READ, 16'h0800, 32'h0);
    `CHK(e, 1'b1)
    repeat (4) @(posedge core_clk);
    `CHK(trapHit, 1'b1)
    fe(16'h0800, 1);
    `CHK(e, 1'b1)
    @(negedge core_clk);
    `CHK(faultCount, 16'h0004)
    `CHK(faultAddr, 16'h0800)
    $display("fault done");
  endtask : t_fault

  // ----------------------------------------
  // data access arriving during a fetch waits for it
  // ----------------------------------------
  task t_hold;
    int n, fo, lo;
    @(posedge core_clk);
    fetchReq <= 1'b1;
    fetchBurst <= 1'b0;
    fetchAddr <= 16'h0010;
    @(posedge core_clk);
    loadReq <= 1'b1;
    loadWe <= 1'b0;
    loadOpt <= OPT_IROM_READ;
    loadAddr <= 16'h0020;
    n = 0;
    fo = 0;
    lo = 0;
    while (lo == 0 && n < 40)
    begin
      @(negedge core_clk);
      n++;
      if (fetchDone === 1'b1)
        fo = n;
      if (loadDone === 1'b1)
      begin
        lo = n;
        q = loadData;
      end
      @(posedge core_clk);
      if (fo != 0)
        fetchReq <= 1'b0;
    end
    loadReq <= 1'b0;
    `CHK(fo != 0 && fo < lo, 1'b1)
    `CHK(q, 32'h1000_0000)
    $display("hold done");
  endtask : t_hold

  task t_contend;
    int n, ord;
    logic fd;
    @(posedge core_clk);
    fetchReq <= 1'b1;
    fetchAddr <= 16'h0010;
    loadReq <= 1'b1;
    loadWe <= 1'b1;
    loadAddr <= 16'h0040;
    n = 0;
    ord = 0;
    fd = 1'b0;
    while (!fd && n < 40)
    begin
      @(negedge core_clk);
      n++;
      if (loadDone === 1'b1)
        ord = n;
      fd = (fetchDone === 1'b1);
      @(posedge core_clk);
      if (ord != 0)
        loadReq <= 1'b0;
    end
    fetchReq <= 1'b0;
    `CHK(ord != 0 && ord < n, 1'b1)
    `CHK(fetchData, 32'hA5A5_0001)
    $display("contend done");
  endtask : t_contend

  task t_dma;
    int n;
    @(posedge core_clk);
    dmaReq <= 1'b1;
    n = 0;
    while (dmaGrant !== 1'b1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    `CHK(dmaGrant, 1'b1)
    @(posedge core_clk);
    fetchReq <= 1'b1;
    fetchAddr <= 16'h0050;
    dmaInstrWdata <= 32'hD0D0_0050;
    repeat (4) @(negedge core_clk);
    `CHK(ira_bus_if_inst.instrReq, 1'b0)
    @(posedge core_clk);
    fetchReq <= 1'b0;
    dmaInstrWe <= 1'b1;
    n = 0;
    while (fetchDone !== 1'b1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    `CHK(fetchDone, 1'b1)
    @(posedge core_clk);
    dmaInstrWe <= 1'b0;
    dmaReq <= 1'b0;
    repeat (6) @(posedge core_clk);
    `CHK(dmaGrant, 1'b0)
    fe(16'h0050, 1);
    `CHK(w[0], 32'hD0D0_0050)
    $display("dma done");
  endtask : t_dma

  initial
  begin
    {rst_n, injectParityErr, fetchReq, fetchBurst, loadReq, loadBurst, loadWe} = '0;
    {dmaReq, dmaInstrWe, trapHit} = '0;
    {fetchAddr, loadAddr, loadWdata, dmaInstrWdata, loadOpt} = '0;
    failures = 0;
    compares = 0;
    cyc = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    `CHK(arbState, ARB_IDLE)
    `CHK(dmaGrant, 1'b0)
    t_rw();
    t_burst();
    t_fault();
    t_contend();
    t_hold();
    t_dma();
    tally_and_finish();
  end
endmodule : tb
